// file: hdl/flic_arbiter.sv
`timescale 1ns/1ps

// Picks the highest level, then the lowest source number; while busy, only a level above the ceiling
module flic_arbiter
    import flic_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] pending,
    input  wire flic_level_t [NUM_SRC-1:0] levels,
    input  wire logic               busy,
    input  wire flic_level_t        ceiling,
    output flic_win_s               win
);

    flic_win_s pick;

    // Later hits overwrite earlier ones: levels rise, sources fall
    always_comb begin
        pick = '0;
        for (int lv = 0; lv < NUM_LEVEL; lv++) begin
            for (int s = NUM_SRC - 1; s >= 0; s--) begin
                if (pending[s] && (levels[s] == flic_level_t'(lv))) begin
                    pick.valid = 1'b1;
                    pick.id    = ID_W'(s);
                    pick.level = flic_level_t'(lv);
                end
            end
        end
    end

    assign win = (busy && (pick.level <= ceiling)) ? '0 : pick;

endmodule

// file: hdl/flic_pkg.sv
package flic_pkg;

    // Source count and widths
    localparam int NUM_SRC    = 10;
    localparam int ID_W       = 4;
    localparam int NUM_LEVEL  = 4;
    localparam int MAIN_SRC   = 7;
    localparam int EXTRA_SRC  = 3;
    localparam int STATUS_W   = 3;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_ENABLE_MAIN  = 8'hA8;
    localparam logic [7:0] IDX_ENABLE_EXTRA = 8'hB1;
    localparam logic [7:0] IDX_PRIO_HIGH    = 8'hB7;
    localparam logic [7:0] IDX_PRIO_LOW     = 8'hB8;
    localparam logic [7:0] IDX_PRIO_EXTRA   = 8'hC0;
    localparam logic [7:0] IDX_EN_SET       = 8'hC1;
    localparam logic [7:0] IDX_EN_CLR       = 8'hC2;
    localparam logic [7:0] IDX_PL_SET       = 8'hC3;
    localparam logic [7:0] IDX_PL_CLR       = 8'hC4;
    localparam logic [7:0] IDX_STATUS       = 8'hC5;
    localparam logic [7:0] IDX_MASK         = 8'hC6;
    localparam logic [7:0] IDX_SERVICE      = 8'hC7;

    // Field positions
    localparam int EN_GLOBAL_BIT   = 7;
    localparam int PRIO_EXTRA_HIGH = 3;
    localparam int ST_TAKEN        = 0;
    localparam int ST_DONE         = 1;
    localparam int ST_STRAY        = 2;

    // Source numbers, in polling order
    localparam logic [3:0] SRC_EXT0   = 4'h0;
    localparam logic [3:0] SRC_TIMER0 = 4'h1;
    localparam logic [3:0] SRC_EXT1   = 4'h2;
    localparam logic [3:0] SRC_TIMER1 = 4'h3;
    localparam logic [3:0] SRC_SERIAL = 4'h4;
    localparam logic [3:0] SRC_TIMER2 = 4'h5;
    localparam logic [3:0] SRC_COUNTR = 4'h6;
    localparam logic [3:0] SRC_KEYPAD = 4'h7;
    localparam logic [3:0] SRC_SPERIF = 4'h8;
    localparam logic [3:0] SRC_TWOWIR = 4'h9;

    // Reset values
    localparam logic [7:0] ENABLE_MAIN_RST  = 8'h00;
    localparam logic [2:0] ENABLE_EXTRA_RST = 3'h0;
    localparam logic [6:0] PRIO_RST         = 7'h00;
    localparam logic [5:0] PRIO_EXTRA_RST   = 6'h00;
    localparam logic [2:0] STATUS_RST       = 3'h0;

    // Vector address per source, indexed by source number
    localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
        16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h004B
    };

    typedef logic [1:0] flic_level_t;

    // Winning request offered to the core
    typedef struct packed {
        logic        valid;
        logic [3:0]  id;
        flic_level_t level;
    } flic_win_s;

    // Data phase of the register bus
    typedef enum logic [0:0] {
        FLIC_IDLE,
        FLIC_WR_DATA
    } flic_bus_e;

endpackage

// file: hdl/flic_top.sv
// Notes on behaviour
// - Ten request sources, each with a vector.
// - Per-source enable bit gates servicing.
// - Global enable gates every source together.
// - High/low bit pair gives level zero-three.
// - Fixed vectors; two-wire moved off shared address.
// - Only a higher level pre-empts a handler.
// - Highest level handler is never pre-empted.
// - Simultaneous requests: higher level served first.
// - Same level: fixed polling order decides.
// - Main enable register layout, global at top.
// - Main enable resets zero; bit set/clear aliases.
// - Each enable blocks or allows its source.
// - Extra enable: serial periph, two-wire, keypad.
// - Low priority register, resets zero, bit access.
// - High priority register, resets zero, byte only.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps

module flic_top
    import flic_pkg::*;
(
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               ce,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic [NUM_SRC-1:0] src_req,
    input  wire logic               cpu_ack,
    input  wire logic               cpu_ret,
    output logic                    cpu_irq,
    output logic [15:0]             cpu_vector,
    output flic_level_t             cpu_level,
    output logic [ID_W-1:0]         cpu_src,
    output logic                    irq
);

    // Register state
    logic [7:0]           enable_main;
    logic [2:0]           enable_extra;
    logic [6:0]           prio_high;
    logic [6:0]           prio_low;
    logic [5:0]           prio_extra;
    logic [STATUS_W-1:0]  status;
    logic [STATUS_W-1:0]  mask;
    logic [NUM_LEVEL-1:0] in_service;
    flic_bus_e            bus_state;
    logic [7:0]           wr_idx;

    // Bus decode
    logic       accept;
    logic       in_map;
    logic [7:0] addr_idx;
    logic       rd_accept;
    logic       wr_accept;
    logic       wr_commit;
    logic [7:0] wdata;
    flic_bus_e  next_bus_state;

    // Access is taken on a valid transfer while the bus is ready
    assign accept    = hsel & hready & htrans[1];
    assign in_map    = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
    assign addr_idx  = in_map ? haddr[9:2] : 8'h00;
    assign rd_accept = accept & ~hwrite;
    assign wr_accept = accept & hwrite;
    assign wr_commit = (bus_state == FLIC_WR_DATA);
    assign wdata     = hwdata[7:0];

    // Writes land one cycle after the address phase, once hwdata stands
    // Write hit wires for the latched write index
    logic wr_en_main;
    logic wr_en_extra;
    logic wr_prio_high;
    logic wr_prio_low;
    logic wr_prio_extra;
    logic wr_en_set;
    logic wr_en_clr;
    logic wr_pl_set;
    logic wr_pl_clr;
    logic wr_mask;

    assign wr_en_main    = wr_commit & (wr_idx == IDX_ENABLE_MAIN);
    assign wr_en_extra   = wr_commit & (wr_idx == IDX_ENABLE_EXTRA);
    assign wr_prio_high  = wr_commit & (wr_idx == IDX_PRIO_HIGH);
    assign wr_prio_low   = wr_commit & (wr_idx == IDX_PRIO_LOW);
    assign wr_prio_extra = wr_commit & (wr_idx == IDX_PRIO_EXTRA);
    assign wr_en_set     = wr_commit & (wr_idx == IDX_EN_SET);
    assign wr_en_clr     = wr_commit & (wr_idx == IDX_EN_CLR);
    assign wr_pl_set     = wr_commit & (wr_idx == IDX_PL_SET);
    assign wr_pl_clr     = wr_commit & (wr_idx == IDX_PL_CLR);
    assign wr_mask       = wr_commit & (wr_idx == IDX_MASK);

    // Read hit wires for the address-phase index
    logic rd_hit_en_main;
    logic rd_hit_en_extra;
    logic rd_hit_prio_high;
    logic rd_hit_prio_low;
    logic rd_hit_prio_extra;
    logic rd_hit_en_set;
    logic rd_hit_en_clr;
    logic rd_hit_pl_set;
    logic rd_hit_pl_clr;
    logic rd_hit_status;
    logic rd_hit_mask;
    logic rd_hit_service;

    // Alias registers read back the register that they modify
    assign rd_hit_en_main    = (addr_idx == IDX_ENABLE_MAIN);
    assign rd_hit_en_extra   = (addr_idx == IDX_ENABLE_EXTRA);
    assign rd_hit_prio_high  = (addr_idx == IDX_PRIO_HIGH);
    assign rd_hit_prio_low   = (addr_idx == IDX_PRIO_LOW);
    assign rd_hit_prio_extra = (addr_idx == IDX_PRIO_EXTRA);
    assign rd_hit_en_set     = (addr_idx == IDX_EN_SET);
    assign rd_hit_en_clr     = (addr_idx == IDX_EN_CLR);
    assign rd_hit_pl_set     = (addr_idx == IDX_PL_SET);
    assign rd_hit_pl_clr     = (addr_idx == IDX_PL_CLR);
    assign rd_hit_status     = (addr_idx == IDX_STATUS);
    assign rd_hit_mask       = (addr_idx == IDX_MASK);
    assign rd_hit_service    = (addr_idx == IDX_SERVICE);

    // Next register values
    logic [7:0]          next_enable_main;
    logic [2:0]          next_enable_extra;
    logic [6:0]          next_prio_high;
    logic [6:0]          next_prio_low;
    logic [5:0]          next_prio_extra;
    logic [STATUS_W-1:0] next_mask;

    assign next_enable_main = wr_en_main ? wdata :
                              wr_en_set  ? (enable_main | wdata) :
                              wr_en_clr  ? (enable_main & ~wdata) :
                              enable_main;

    assign next_enable_extra = wr_en_extra ? wdata[2:0] : enable_extra;

    assign next_prio_low = wr_prio_low ? wdata[6:0] :
                           wr_pl_set   ? (prio_low | wdata[6:0]) :
                           wr_pl_clr   ? (prio_low & ~wdata[6:0]) :
                           prio_low;

    assign next_prio_high  = wr_prio_high ? wdata[6:0] : prio_high;
    assign next_prio_extra = wr_prio_extra ? wdata[5:0] : prio_extra;
    assign next_mask       = wr_mask ? wdata[STATUS_W-1:0] : mask;

    // Per-source enable and level
    logic [NUM_SRC-1:0]      src_enable;
    flic_level_t [NUM_SRC-1:0] src_level;

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        if (i < MAIN_SRC) begin : g_main
            assign src_enable[i] = enable_main[i];
            assign src_level[i]  = {prio_high[i], prio_low[i]};
        end else begin : g_extra
            // Keypad sits in bit 0, two-wire in bit 1, serial periph in bit 2
            localparam int EN_BIT = (i == MAIN_SRC) ? 0 : (NUM_SRC - i);
            assign src_enable[i] = enable_extra[EN_BIT];
            assign src_level[i]  = {prio_extra[PRIO_EXTRA_HIGH+i-MAIN_SRC],
                                    prio_extra[i-MAIN_SRC]};
        end
    end

    // Requests that may compete
    logic [NUM_SRC-1:0] pending;

    assign pending = src_req & src_enable & {NUM_SRC{enable_main[EN_GLOBAL_BIT]}};

    // Current in-service level
    logic        busy;
    flic_level_t ceiling;

    // Highest level in service; zero when no handler runs
    assign busy    = |in_service;
    assign ceiling = in_service[3] ? 2'h3 :
                     in_service[2] ? 2'h2 :
                     in_service[1] ? 2'h1 : 2'h0;

    // Arbitration against the ceiling
    flic_win_s win;

    // The offer is registered, so it lags the requests by one cycle
    flic_arbiter u_arbiter (
        .pending (pending),
        .levels  (src_level),
        .busy    (busy),
        .ceiling (ceiling),
        .win     (win)
    );

    // Core handshake: the offer must still stand when acknowledged
    logic                 take;
    logic                 done;
    logic [NUM_LEVEL-1:0] take_mask;
    logic [NUM_LEVEL-1:0] done_mask;
    logic [NUM_LEVEL-1:0] next_in_service;

    // A late acknowledge, after the winner changed, is logged as stray
    assign take      = cpu_ack & cpu_irq & win.valid & (win.id == cpu_src);
    assign done      = cpu_ret & busy;
    assign take_mask = take ? (NUM_LEVEL'(1) << cpu_level) : '0;
    assign done_mask = done ? (NUM_LEVEL'(1) << ceiling) : '0;

    // Release clears first, so a return and a take in one cycle both apply
    // handler end releases level
    assign next_in_service = (in_service & ~done_mask) | take_mask;

    // Sticky events; a read of status clears, a new event wins
    logic                rd_status;
    logic [STATUS_W-1:0] events;
    logic [STATUS_W-1:0] next_status;

    assign rd_status           = rd_accept & rd_hit_status;
    assign events[ST_TAKEN]    = take;
    assign events[ST_DONE]     = done;
    assign events[ST_STRAY]    = cpu_ack & ~take;
    assign next_status         = (status & ~{STATUS_W{rd_status}}) | events;

    // Read data selection
    logic [7:0] rd_value;

    assign rd_value = rd_hit_en_main    ? enable_main :
                      rd_hit_en_set     ? enable_main :
                      rd_hit_en_clr     ? enable_main :
                      rd_hit_en_extra   ? {5'h00, enable_extra} :
                      rd_hit_prio_high  ? {1'h0, prio_high} :
                      rd_hit_prio_low   ? {1'h0, prio_low} :
                      rd_hit_pl_set     ? {1'h0, prio_low} :
                      rd_hit_pl_clr     ? {1'h0, prio_low} :
                      rd_hit_prio_extra ? {2'h0, prio_extra} :
                      rd_hit_status     ? {5'h00, status} :
                      rd_hit_mask       ? {5'h00, mask} :
                      rd_hit_service    ? {cpu_src, in_service} :
                      8'h00;

    // A write stretches its data phase by one wait state
    assign next_bus_state = wr_accept ? FLIC_WR_DATA : FLIC_IDLE;

    // Bus phase and response
    // The response is held low: every transfer ends OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= FLIC_IDLE;
            wr_idx    <= 8'h00;
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
        end else if (ce) begin
            bus_state <= next_bus_state;
            wr_idx    <= wr_accept ? addr_idx : wr_idx;
            hreadyout <= (next_bus_state == FLIC_IDLE);
            hresp     <= 1'h0;
        end
    end

    // Read data is latched in the address phase
    // An event in the clearing cycle stays set for the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ce && rd_accept) begin
            hrdata <= {24'h000000, rd_value};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_main  <= ENABLE_MAIN_RST;
            enable_extra <= ENABLE_EXTRA_RST;
            prio_high    <= PRIO_RST;
            prio_low     <= PRIO_RST;
            prio_extra   <= PRIO_EXTRA_RST;
            mask         <= STATUS_RST;
        end else if (ce) begin
            enable_main  <= next_enable_main;
            enable_extra <= next_enable_extra;
            prio_high    <= next_prio_high;
            prio_low     <= next_prio_low;
            prio_extra   <= next_prio_extra;
            mask         <= next_mask;
        end
    end

    // In-service stack and sticky status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_service <= '0;
            status     <= STATUS_RST;
        end else if (ce) begin
            in_service <= next_in_service;
            status     <= next_status;
        end
    end

    // Offer to the core, registered from the arbiter
    // fixed vector per source
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_irq    <= 1'h0;
            cpu_src    <= SRC_EXT0;
            cpu_level  <= 2'h0;
            cpu_vector <= 16'h0000;
        end else if (ce) begin
            cpu_irq    <= win.valid;
            cpu_src    <= win.id;
            cpu_level  <= win.level;
            cpu_vector <= win.valid ? VECTOR_TABLE[win.id] : 16'h0000;
        end
    end

    // Level interrupt from unmasked sticky events
    // Registered, so the pin cannot glitch while status settles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'h0;
        end else if (ce) begin
            irq <= |(status & mask);
        end
    end

endmodule

// file: tb/flic_cpu_model.sv
`timescale 1ns/1ps
// Core side: takes offers when allowed and ends handlers on command
module flic_cpu_model
    import flic_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        cpu_irq,
    input  wire logic [15:0] cpu_vector,
    input  wire logic        take_en,
    input  wire logic        ret_cmd,
    output logic             cpu_ack,
    output logic             cpu_ret,
    output logic [15:0]      taken_vec,
    output logic [7:0]       take_cnt
);
    logic [1:0] cool;
    // One-cycle ack, then wait three cycles before looking again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_ack   <= 1'b0;
            cpu_ret   <= 1'b0;
            taken_vec <= 16'h0000;
            take_cnt  <= 8'h00;
            cool      <= 2'h0;
        end else begin
            cpu_ack <= 1'b0;
            cpu_ret <= ret_cmd;
            if (cool != 2'h0) begin
                cool <= cool - 2'h1;
            end else if (take_en && cpu_irq) begin
                cpu_ack   <= 1'b1;
                taken_vec <= cpu_vector;
                take_cnt  <= take_cnt + 8'h01;
                cool      <= 2'h3;
            end
        end
    end
endmodule

// file: tb/flic_props.sv
`timescale 1ns/1ps
// Port-level checks of the interrupt controller
module flic_props
    import flic_pkg::*;
(
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               ce,
    input wire logic               hsel,
    input wire logic               hready,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hreadyout,
    input wire logic [31:0]        hrdata,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic               cpu_ack,
    input wire logic               cpu_ret,
    input wire logic               cpu_irq,
    input wire logic [15:0]        cpu_vector,
    input wire flic_level_t        cpu_level,
    input wire logic [ID_W-1:0]    cpu_src
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Write data phase: one wait cycle, then ready
    sequence s_wr_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    // Take of a standing offer with the requests unchanged
    sequence s_take;
        cpu_ack && cpu_irq && !cpu_ret && $stable(src_req);
    endsequence
    // Register bus
    property p_wr_wait; hsel && hready && htrans[1] && hwrite && ce |=> s_wr_wait; endproperty
    a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");
    property p_rd_upper; hrdata[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_rst_quiet; $rose(hresetn) |-> !cpu_irq && hreadyout && hrdata == 32'h0; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("not idle after reset");
    // Offer and vectors
    property p_req_cause; cpu_irq |-> |($past(src_req) & (NUM_SRC'(1) << cpu_src)); endproperty
    a_req_cause: assert property (p_req_cause) else $error("offer without request");
    property p_vec_map; cpu_irq |-> cpu_vector == 16'h0003 + {9'h0, cpu_src, 3'b000}; endproperty
    a_vec_map: assert property (p_vec_map) else $error("vector wrong");
    property p_vec_zero; !cpu_irq |-> cpu_vector == 16'h0000; endproperty
    a_vec_zero: assert property (p_vec_zero) else $error("vector without offer");
    // Nesting after a take
    property p_top_hold; s_take ##0 cpu_level == 2'h3 |-> ##2 (!cpu_irq) [*3]; endproperty
    a_top_hold: assert property (p_top_hold) else $error("top level pre-empted");
    property p_preempt; s_take |-> ##2 (!cpu_irq || cpu_level > $past(cpu_level, 2)); endproperty
    a_preempt: assert property (p_preempt) else $error("same level pre-empted");
endmodule

bind flic_top flic_props flic_props_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite),
    .hreadyout(hreadyout), .hrdata(hrdata), .src_req(src_req), .cpu_ack(cpu_ack),
    .cpu_ret(cpu_ret), .cpu_irq(cpu_irq), .cpu_vector(cpu_vector),
    .cpu_level(cpu_level), .cpu_src(cpu_src));

// file: tb/flic_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the interrupt controller
module flic_tb_top
    import flic_pkg::*;
;
    logic               hclk = 1'b0;
    logic               hresetn = 1'b0;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = 32'h0;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'b0;
    logic [31:0]        hwdata = 32'h0;
    logic [NUM_SRC-1:0] src_req = 10'h000;
    logic               take_en = 1'b0;
    logic               ret_cmd = 1'b0;
    logic               hreadyout, hresp, cpu_ack, cpu_ret, cpu_irq, irq;
    logic [31:0]        hrdata;
    logic [15:0]        cpu_vector, taken_vec;
    flic_level_t        cpu_level;
    logic [ID_W-1:0]    cpu_src;
    logic [7:0]         take_cnt;
    int                 error_cnt = 0;
    int                 num_checks = 0;

    always #20 hclk = ~hclk;

    flic_top flic_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .src_req(src_req), .cpu_ack(cpu_ack), .cpu_ret(cpu_ret), .cpu_irq(cpu_irq),
        .cpu_vector(cpu_vector), .cpu_level(cpu_level), .cpu_src(cpu_src), .irq(irq));
    flic_cpu_model flic_cpu_model_i (.hclk(hclk), .hresetn(hresetn), .cpu_irq(cpu_irq),
        .cpu_vector(cpu_vector), .take_en(take_en), .ret_cmd(ret_cmd), .cpu_ack(cpu_ack),
        .cpu_ret(cpu_ret), .taken_vec(taken_vec), .take_cnt(take_cnt));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One single AHB-Lite transfer of a word
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Register write, and read with compare
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, {24'h0, d}, rd);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        check(rd, {24'h0, exp});
        check(hresp, 1'b0);
    endtask
    // Offer state once the arbiter has settled
    task automatic offer(input logic v, input logic [3:0] s);
        repeat (4) @(posedge hclk);
        check({cpu_irq, cpu_src}, {v, v ? s : cpu_src});
        check(cpu_vector, v ? 16'h0003 + {9'h0, s, 3'b000} : 16'h0000);
    endtask
    // Wait for the core to take offer number n
    task automatic take(input logic [7:0] n, input logic [15:0] vec);
        int k;
        k = 0;
        while (take_cnt !== n && k < 40) begin
            @(posedge hclk);
            k++;
        end
        check({take_cnt, taken_vec}, {n, vec});
    endtask
    task automatic ret;
        @(posedge hclk);
        ret_cmd <= 1'b1;
        @(posedge hclk);
        ret_cmd <= 1'b0;
    endtask

    // Reset values, masks of reserved bits, set/clear aliases, unmapped space
    task automatic t_regs;
        rdchk(IDX_ENABLE_MAIN, 8'h00);
        rdchk(IDX_PRIO_LOW, 8'h00);
        rdchk(IDX_PRIO_HIGH, 8'h00);
        wr(IDX_ENABLE_EXTRA, 8'hFF);
        rdchk(IDX_ENABLE_EXTRA, 8'h07);
        wr(IDX_PRIO_HIGH, 8'hFF);
        rdchk(IDX_PRIO_HIGH, 8'h7F);
        wr(IDX_EN_SET, 8'h91);
        wr(IDX_EN_CLR, 8'h01);
        rdchk(IDX_ENABLE_MAIN, 8'h90);
        wr(IDX_PL_SET, 8'h42);
        wr(IDX_PL_CLR, 8'h02);
        rdchk(IDX_PRIO_LOW, 8'h40);
        wr(8'h20, 8'hFF);
        rdchk(8'h20, 8'h00);
        wr(IDX_PRIO_HIGH, 8'h00);
        wr(IDX_PRIO_LOW, 8'h00);
    endtask
    // Every source alone: vector, then blocked by its own enable; then all requests at once, blocked by the global one
    task automatic t_src;
        logic [7:0] m;
        logic [7:0] x;
        for (int i = 0; i < NUM_SRC; i++) begin
            m = 8'hFF;
            x = 8'h07;
            wr(IDX_ENABLE_MAIN, m);
            wr(IDX_ENABLE_EXTRA, x);
            src_req <= 10'h001 << i;
            offer(1'b1, i[3:0]);
            if (i < 7) m[i] = 1'b0;
            else x[(i == 7) ? 0 : (i == 8) ? 2 : 1] = 1'b0;
            wr(IDX_ENABLE_MAIN, m);
            wr(IDX_ENABLE_EXTRA, x);
            offer(1'b0, 4'h0);
        end
        wr(IDX_ENABLE_MAIN, 8'h7F);
        src_req <= 10'h3FF;
        offer(1'b0, 4'h0);
        wr(IDX_ENABLE_MAIN, 8'h80);
        wr(IDX_ENABLE_EXTRA, 8'h00);
        offer(1'b0, 4'h0);
    endtask
    // Level codes, level order and polling order
    task automatic t_lvl;
        wr(IDX_ENABLE_MAIN, 8'hFF);
        wr(IDX_ENABLE_EXTRA, 8'h07);
        src_req <= 10'h002;
        for (int l = 0; l < 4; l++) begin
            wr(IDX_PRIO_HIGH, {6'h0, l[1], 1'b0});
            wr(IDX_PRIO_LOW, {6'h0, l[0], 1'b0});
            offer(1'b1, 4'h1);
            check(cpu_level, l[1:0]);
        end
        wr(IDX_PRIO_HIGH, 8'h20);
        wr(IDX_PRIO_LOW, 8'h00);
        src_req <= 10'h021;
        offer(1'b1, 4'h5);
        wr(IDX_PRIO_HIGH, 8'h00);
        wr(IDX_PRIO_LOW, 8'h7F);
        wr(IDX_PRIO_EXTRA, 8'h07);
        src_req <= 10'h308;
        offer(1'b1, 4'h3);
        src_req <= 10'h300;
        offer(1'b1, 4'h8);
        src_req <= 10'h280;
        offer(1'b1, 4'h7);
        src_req <= 10'h000;
    endtask
    // Nesting: levels 1,1,2,0,3,3 with the core taking and returning
    task automatic t_nest;
        wr(IDX_PRIO_LOW, 8'h33);
        wr(IDX_PRIO_HIGH, 8'h34);
        wr(IDX_PRIO_EXTRA, 8'h00);
        take_en <= 1'b1;
        src_req <= 10'h001;
        take(8'd1, 16'h0003);
        src_req <= 10'h00A;
        offer(1'b0, 4'h0);
        src_req <= 10'h00E;
        take(8'd2, 16'h0013);
        src_req <= 10'h00A;
        ret;
        offer(1'b0, 4'h0);
        ret;
        take(8'd3, 16'h000B);
        src_req <= 10'h018;
        take(8'd4, 16'h0023);
        src_req <= 10'h028;
        offer(1'b0, 4'h0);
        ret;
        take(8'd5, 16'h002B);
        src_req <= 10'h008;
        ret;
        ret;
        take(8'd6, 16'h001B);
        src_req <= 10'h000;
        ret;
    endtask
    // Status, mask and the level interrupt output
    task automatic t_irq;
        logic [31:0] rd;
        bus(1'b0, IDX_STATUS, 32'h0, rd);
        wr(IDX_MASK, 8'h03);
        offer(1'b0, 4'h0);
        check(irq, 1'b0);
        src_req <= 10'h001;
        take(8'd7, 16'h0003);
        src_req <= 10'h000;
        offer(1'b0, 4'h0);
        check(irq, 1'b1);
        rdchk(IDX_STATUS, 8'h01);
        offer(1'b0, 4'h0);
        check(irq, 1'b0);
        wr(IDX_MASK, 8'h00);
        ret;
        offer(1'b0, 4'h0);
        check(irq, 1'b0);
        rdchk(IDX_STATUS, 8'h02);
        take_en <= 1'b0;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_src;
        t_lvl;
        t_nest;
        t_irq;
        test_done;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        test_done;
    end
endmodule
